// ===== inc/asw_pkg.sv
`default_nettype none
package asw_pkg;

   // Pin and address widths
   localparam int ADDR_W = 21;
   localparam int DATA_W = 8;
   localparam int SYNC_W = DATA_W + 1;

   // Clock
   localparam int CLK_PERIOD_NS = 25;

   // Write timing, 5 V grade and 3.3 V grade
   localparam int WRITE_PULSE_MIN_NS_5V         = 55;
   localparam int WRITE_PULSE_MIN_NS_3V         = 65;
   localparam int SELECT_PULSE_MIN_NS_5V        = 55;
   localparam int SELECT_PULSE_MIN_NS_3V        = 75;
   localparam int ADDRESS_SETUP_TO_WRITE_END_NS_5V = 65;
   localparam int ADDRESS_SETUP_TO_WRITE_END_NS_3V = 75;
   localparam int DATA_SETUP_TO_WRITE_END_NS_5V = 30;
   localparam int DATA_SETUP_TO_WRITE_END_NS_3V = 35;
   localparam int ADDRESS_HOLD_AFTER_WRITE_NS   = 5;
   localparam int ADDRESS_HOLD_AFTER_SELECT_NS  = 15;
   localparam int DATA_HOLD_AFTER_SELECT_NS     = 15;
   localparam int WRITE_CYCLE_MIN_NS            = 85;
   // Read timing used for the read side of the controller
   localparam int READ_ACCESS_MAX_NS            = 85;
   localparam int OUTPUT_FLOAT_MAX_NS           = 35;
   localparam int SYNC_STAGES                   = 2;

   // Worst case of both grades, so one build serves either part
   localparam int WRITE_PULSE_NS = (WRITE_PULSE_MIN_NS_3V > WRITE_PULSE_MIN_NS_5V) ?
                                   WRITE_PULSE_MIN_NS_3V : WRITE_PULSE_MIN_NS_5V;
   localparam int ADDR_SETUP_NS  = (ADDRESS_SETUP_TO_WRITE_END_NS_3V >
                                    ADDRESS_SETUP_TO_WRITE_END_NS_5V) ?
                                   ADDRESS_SETUP_TO_WRITE_END_NS_3V :
                                   ADDRESS_SETUP_TO_WRITE_END_NS_5V;

   // Least times round up to whole cycles
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_HOLD_W_CYC = (ADDRESS_HOLD_AFTER_WRITE_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int ADDR_HOLD_E_CYC = (ADDRESS_HOLD_AFTER_SELECT_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int READ_WAIT_CYC   = (READ_ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                    + SYNC_STAGES;
   localparam int FLOAT_CYC       = (OUTPUT_FLOAT_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int TIMER_W = 4;

   // Reset values of the pins
   localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } asw_req_t;

   typedef struct packed {
      logic              chip_select_n;
      logic              write_strobe_n;
      logic              output_enable_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data_bus_out;
      logic              data_bus_oe_n;
   } asw_pins_t;

   localparam asw_pins_t PINS_IDLE = '{chip_select_n: 1'b1, write_strobe_n: 1'b1,
                                       output_enable_n: 1'b1, addr: ADDR_RESET,
                                       data_bus_out: DATA_RESET, data_bus_oe_n: 1'b1};

   typedef enum logic [2:0] {
      ASW_IDLE    = 3'b000,
      ASW_SETUP   = 3'b001,
      ASW_STROBE  = 3'b010,
      ASW_WEND    = 3'b011,
      ASW_RELEASE = 3'b100,
      ASW_RDWAIT  = 3'b101,
      ASW_FLOAT   = 3'b110
   } asw_state_t;

endpackage
`default_nettype wire

// ===== core/asw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asw_sync
   import asw_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset,
   // Asynchronous levels in, synchronised levels out
   input  wire logic [SYNC_W-1:0] d,
   output var  logic [SYNC_W-1:0] q
);

   logic [SYNC_W-1:0] stage1;
   logic [SYNC_W-1:0] next_stage1;
   logic [SYNC_W-1:0] next_q;

   genvar i;
   generate
      for (i = 0; i < SYNC_W; i++) begin : g_bit
         always_comb begin
            next_stage1[i] = d[i];
            next_q[i]      = stage1[i];
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stage1 <= '0;
         q      <= '0;
      end else begin
         stage1 <= next_stage1;
         q      <= next_q;
      end
   end

endmodule // asw_sync
`default_nettype wire

// ===== core/asw_host.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01 - Memory writes while write strobe and chip select are both low.
// R02 - Write starts at the later falling edge of strobe or select.
// R03 - Write ends, byte committed, at the earlier rising edge.
// R04 - Host holds address steady across the whole write.
// R05 - Address held 15 ns after select rise, 5 ns after strobe rise.
// R06 - Data valid 30/35 ns before write end and held afterwards.
// R07 - Host keeps output enable high during writes.
// R08 - Strobe low floats driven outputs within 25/30 ns.
// R09 - Select and strobe falling together never drive the outputs.
// R10 - Write strobe low at least 55/65 ns.
// R11 - Chip select low at least 55/75 ns in select-led writes.
// R12 - Address valid 65/75 ns before the write-ending edge.
// R13 - On power fail memory deselects after protect delay, ignoring inputs.
// R14 - Access in progress at power fail completes unless protect delay expires.
// R15 - Write protection stays for recovery delay after supply returns.
// R16 - Twenty-one address lines select one of 2,097,152 bytes.
// R17 - Data lines driven only with select and output enable low, strobe high.
// R18 - Data captured at write end when protection is inactive.
module asw_host
   import asw_pkg::*;
#(
   parameter logic [15:0] RECOVERY_CYCLES = 16'h1f40
)(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset,
   // Request side
   input  wire logic              req_valid,
   input  wire asw_req_t          req,
   output var  logic              req_ready,
   output var  logic              rsp_valid,
   output var  logic [DATA_W-1:0] rsp_rdata,
   // Supply monitor level, asynchronous
   input  wire logic              supply_ok,
   output var  logic              protected_hold,
   // Memory pins
   output var  asw_pins_t         pins,
   input  wire logic [DATA_W-1:0] data_bus_in
);

   // Bus levels are sampled only once long settled, so per-bit sync is safe
   logic [SYNC_W-1:0] synced;
   logic [DATA_W-1:0] data_in_s;
   logic              supply_ok_s;

   asw_sync u_sync (
      .ref_clk (ref_clk),
      .reset   (reset),
      .d       ({supply_ok, data_bus_in}),
      .q       (synced)
   );

   assign data_in_s   = synced[DATA_W-1:0];
   assign supply_ok_s = synced[DATA_W];

   // Supply watch: no new access while the supply is out or recovering
   logic        low_seen;
   logic        next_low_seen;
   logic [15:0] recover_cnt;
   logic [15:0] next_recover_cnt;
   logic        next_protected_hold;

   always_comb begin
      next_low_seen       = low_seen;
      next_recover_cnt    = recover_cnt;
      next_protected_hold = protected_hold;
      if (!supply_ok_s) begin
         next_low_seen       = 1'b1;
         next_recover_cnt    = RECOVERY_CYCLES;
         next_protected_hold = 1'b1;
      end else if (low_seen) begin
         // Memory keeps itself protected a while after recovery
         if (recover_cnt == 16'h0000) begin // R15
            next_low_seen       = 1'b0;
            next_protected_hold = 1'b0;
         end else begin
            next_recover_cnt = recover_cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         // Reset counts as a fresh power-up, so the hold runs first
         low_seen       <= 1'b1;
         recover_cnt    <= 16'h0000;
         protected_hold <= 1'b1;
      end else begin
         low_seen       <= next_low_seen;
         recover_cnt    <= next_recover_cnt;
         protected_hold <= next_protected_hold;
      end
   end

   // Access sequencer
   asw_state_t          state;
   asw_state_t          next_state;
   logic [TIMER_W-1:0]  timer;
   logic [TIMER_W-1:0]  next_timer;
   asw_pins_t           next_pins;
   logic                next_req_ready;
   logic                next_rsp_valid;
   logic [DATA_W-1:0]   next_rsp_rdata;

   always_comb begin
      next_state     = state;
      next_timer     = timer;
      next_pins      = pins;
      next_req_ready = 1'b0;
      next_rsp_valid = 1'b0;
      next_rsp_rdata = rsp_rdata;
      // Countdown runs on its own; each state but IDLE reloads it on entry
      if (timer != '0) begin
         next_timer = timer - TIMER_W'(1);
      end
      unique case (state)
         ASW_IDLE: begin
            next_pins      = PINS_IDLE;
            // Only sample new work while the memory can accept it
            next_req_ready = !protected_hold && !next_protected_hold;
            if (req_valid && req_ready) begin
               next_state                 = ASW_SETUP;
               next_req_ready             = 1'b0;
               // Address and select first, strobe one cycle later
               next_pins.addr             = req.addr; // R16
               next_pins.chip_select_n    = 1'b0;
               next_pins.output_enable_n  = 1'b1; // R07
               next_pins.write_strobe_n   = 1'b1;
               next_pins.data_bus_out     = req.data;
               next_pins.data_bus_oe_n    = !req.write; // R06
               next_timer                 = '0;
            end
         end

         ASW_SETUP: begin
            if (pins.data_bus_oe_n) begin
               next_state                = ASW_RDWAIT;
               next_pins.output_enable_n = 1'b0;
               next_timer                = TIMER_W'(READ_WAIT_CYC - 1);
            end else begin
               // Strobe falls after select: the write starts here
               next_state               = ASW_STROBE; // R02
               next_pins.write_strobe_n = 1'b0; // R01
               next_timer               = TIMER_W'(WRITE_PULSE_CYC - 1);
            end
         end

         ASW_STROBE: begin
            if (timer == '0) begin // R10
               // Strobe rises first and ends the write; address and data stay
               next_state               = ASW_WEND; // R03
               next_pins.write_strobe_n = 1'b1; // R12
               next_timer               = TIMER_W'(ADDR_HOLD_W_CYC - 1);
            end
         end

         ASW_WEND: begin
            if (timer == '0) begin // R05
               next_state              = ASW_RELEASE;
               next_pins.chip_select_n = 1'b1; // R11
               next_timer              = TIMER_W'(ADDR_HOLD_E_CYC - 1);
            end
         end

         ASW_RELEASE: begin
            // Address and data held past select rise
            if (timer == '0) begin // R04
               next_state     = ASW_IDLE;
               next_pins      = PINS_IDLE;
               next_rsp_valid = 1'b1;
            end
         end

         ASW_RDWAIT: begin
            // Read waits out access time plus the synchroniser latency
            if (timer == '0) begin
               next_state                = ASW_FLOAT;
               next_rsp_rdata            = data_in_s;
               next_pins.output_enable_n = 1'b1;
               next_pins.chip_select_n   = 1'b1;
               next_timer                = TIMER_W'(FLOAT_CYC - 1);
            end
         end

         ASW_FLOAT: begin
            // Memory outputs may still drive; do not turn the bus yet
            if (timer == '0) begin // R17
               next_state     = ASW_IDLE;
               next_pins      = PINS_IDLE;
               next_rsp_valid = 1'b1;
            end
         end

         default: begin
            next_state = ASW_IDLE;
            next_pins  = PINS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state     <= ASW_IDLE;
         timer     <= '0;
         pins      <= PINS_IDLE;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= DATA_RESET;
      end else begin
         state     <= next_state;
         timer     <= next_timer;
         pins      <= next_pins;
         req_ready <= next_req_ready;
         rsp_valid <= next_rsp_valid;
         rsp_rdata <= next_rsp_rdata;
      end
   end

endmodule // asw_host
`default_nettype wire

// ===== test/asw_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module asw_host_monitor
   import asw_pkg::*;
#(
   parameter logic [15:0] RECOVERY_CYCLES = 16'h1f40
)(
   // Clock, reset, request side
   input wire logic              ref_clk,
   input wire logic              reset,
   input wire logic              req_valid,
   input wire asw_req_t          req,
   input wire logic              req_ready,
   input wire logic              rsp_valid,
   input wire logic [DATA_W-1:0] rsp_rdata,
   // Supply and memory pins
   input wire logic              supply_ok,
   input wire logic              protected_hold,
   input wire asw_pins_t         pins,
   input wire logic [DATA_W-1:0] data_bus_in
);
   localparam int REC_LO = RECOVERY_CYCLES + 1;
   localparam int REC_HI = RECOVERY_CYCLES + 6;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   property p_walk;
      req_valid && req_ready && req.write |=> !pins.chip_select_n && !pins.data_bus_oe_n
         ##1 !pins.write_strobe_n ##3 pins.write_strobe_n ##2 rsp_valid;
   endproperty
   a_walk: assert property (p_walk) else $error("write walk wrong");
   property p_we_pulse;
      $fell(pins.write_strobe_n) |-> (!pins.write_strobe_n && !pins.chip_select_n)[*3];
   endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("strobe too short");
   property p_cs_pulse;
      $fell(pins.chip_select_n) |-> !pins.chip_select_n[*5];
   endproperty
   a_cs_pulse: assert property (p_cs_pulse) else $error("select too short");
   property p_addr;
      $past(!pins.chip_select_n) && !pins.chip_select_n |-> $stable(pins.addr);
   endproperty
   a_addr: assert property (p_addr) else $error("address moved");
   property p_hold;
      $rose(pins.chip_select_n) |-> $stable(pins.addr) && pins.write_strobe_n;
   endproperty
   a_hold: assert property (p_hold) else $error("address hold short");
   property p_setup;
      $rose(pins.write_strobe_n) |-> $past(pins.addr, 3) == pins.addr && !pins.data_bus_oe_n
         && $past(pins.data_bus_out, 3) == pins.data_bus_out;
   endproperty
   a_setup: assert property (p_setup) else $error("setup short");
   property p_oe;
      !pins.write_strobe_n || !pins.data_bus_oe_n |-> pins.output_enable_n;
   endproperty
   a_oe: assert property (p_oe) else $error("output enable low in write");
   property p_fail;
      $fell(supply_ok) |-> ##[2:4] protected_hold ##1 !req_ready;
   endproperty
   a_fail: assert property (p_fail) else $error("no hold on supply loss");
   property p_recover;
      $rose(supply_ok) |-> protected_hold[*3] ##[REC_LO:REC_HI] !protected_hold;
   endproperty
   a_recover: assert property (p_recover) else $error("recovery count wrong");
endmodule // asw_host_monitor
`default_nettype wire

// ===== test/asw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module asw_mem_model
   import asw_pkg::*;
#(
   parameter int PROTECT_NS = 300,
   parameter int RECOVER_NS = 100
)(
   // Host pins and bus level
   input  wire logic              supply_ok,
   input  wire asw_pins_t         pins,
   input  wire logic [DATA_W-1:0] bus,
   // Memory drive onto the bus
   output var  logic              mem_drive,
   output var  logic [DATA_W-1:0] mem_data
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic              prot = 1'b0;
   logic              wr_prev = 1'b0;
   logic              wr_on;
   always @(supply_ok) begin
      if (supply_ok !== 1'b1)
         prot <= #(PROTECT_NS) 1'b1;
      else
         prot <= #(RECOVER_NS) 1'b0;
   end
   assign wr_on = !pins.chip_select_n && !pins.write_strobe_n;
   // Commit on the first of strobe or select to rise, unless protected
   always @(wr_on) begin
      if (wr_prev && wr_on !== 1'b1 && !prot)
         mem[pins.addr] = bus;
      wr_prev = (wr_on === 1'b1);
   end
   assign mem_drive = !pins.chip_select_n && !pins.output_enable_n && pins.write_strobe_n
                      && !prot;
   always @(pins or wr_prev) mem_data = mem[pins.addr];
endmodule // asw_mem_model
`default_nettype wire

// ===== test/tb_async_sram_write_powerfail.sv
`timescale 1ns/1ps
`default_nettype none
module tb_async_sram_write_powerfail;
   import asw_pkg::*;
   localparam logic [15:0] REC = 16'h0004;
   logic              ref_clk, reset, req_valid, req_ready, rsp_valid;
   logic              supply_ok, protected_hold, mem_drive;
   asw_req_t          req;
   asw_pins_t         pins;
   logic [DATA_W-1:0] rsp_rdata, mem_data, bus;
   logic [DATA_W-1:0] float_pat = 8'h5a;
   int                n_errors, total_checks;
   asw_host #(.RECOVERY_CYCLES(REC)) dut (.ref_clk(ref_clk), .reset(reset),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .supply_ok(supply_ok), .protected_hold(protected_hold),
      .pins(pins), .data_bus_in(bus));
   asw_mem_model model (.supply_ok(supply_ok), .pins(pins), .bus(bus),
      .mem_drive(mem_drive), .mem_data(mem_data));
   // Released bus toggles so a stale byte never reads back
   assign bus = !pins.data_bus_oe_n ? pins.data_bus_out : (mem_drive ? mem_data : float_pat);
   always @(posedge ref_clk) float_pat <= ~float_pat;
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
                         output int lat);
      int n;
      @(negedge ref_clk);
      req_valid = 1'b1;
      req = '{write: wr, addr: a, data: d};
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      req_valid = 1'b0;
      lat = 1;
      while (rsp_valid !== 1'b1 && lat < 100) begin
         @(negedge ref_clk);
         lat++;
      end
      rd = rsp_rdata;
      if (n >= 100 || lat >= 100) n_errors++;
   endtask
   task automatic t_reset;
      int n;
      @(negedge ref_clk);
      check(pins, PINS_IDLE);
      check(protected_hold, 1'b1);
      reset = 1'b0;
      n = 0;
      while (req_ready !== 1'b1 && n < 30) begin
         @(negedge ref_clk);
         n++;
      end
      check(n, SYNC_STAGES + int'(REC) + 2);
      $display("test reset done");
   endtask
   task automatic t_rw;
      logic [ADDR_W-1:0] a [3] = '{21'h1fffff, 21'h000000, 21'h0a5a5a};
      logic [DATA_W-1:0] rd;
      int                lat;
      for (int i = 0; i < 3; i++) begin
         access(1'b1, a[i], a[i][7:0] ^ 8'h3c, rd, lat);
         check(lat, 7);
      end
      access(1'b1, a[0], 8'h81, rd, lat);
      for (int i = 0; i < 3; i++) begin
         access(1'b0, a[i], 8'h00, rd, lat);
         check(lat, 10);
         check(rd, i == 0 ? 8'h81 : a[i][7:0] ^ 8'h3c);
      end
      $display("test write read done");
   endtask
   task automatic t_fail;
      logic [DATA_W-1:0] rd;
      int                lat;
      fork
         access(1'b1, 21'h012345, 8'h96, rd, lat);
         begin
            repeat (3) @(negedge ref_clk);
            supply_ok = 1'b0;
         end
      join
      check(lat, 7);
      repeat (4) @(negedge ref_clk);
      check({protected_hold, req_ready}, 2'b10);
      supply_ok = 1'b1;
      access(1'b0, 21'h012345, 8'h00, rd, lat);
      check(rd, 8'h96);
      $display("test power fail done");
   endtask
   initial begin
      #100us;
      n_errors++;
      test_done;
   end
   initial begin
      reset = 1'b1;
      req_valid = 1'b0;
      req = '0;
      supply_ok = 1'b1;
      n_errors = 0;
      total_checks = 0;
      repeat (10) @(posedge ref_clk);
      t_reset;
      t_rw;
      t_fail;
      test_done;
   end
endmodule // tb_async_sram_write_powerfail
bind asw_host asw_host_monitor #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_mon (.ref_clk(ref_clk),
   .reset(reset), .req_valid(req_valid), .req(req), .req_ready(req_ready),
   .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .supply_ok(supply_ok),
   .protected_hold(protected_hold), .pins(pins), .data_bus_in(data_bus_in));
`default_nettype wire
